/* File: verilog/shrp_port.v */
// serial host register port: shift engine and register storage
`timescale 1ns/1ns
`include "shrp_regs.vh"
module shrp_port (
  input wire CLK_SYS_IN,
  input wire RESET_IN,
  input wire MODE_TEST_IN,
  input wire BURST_CLK_IN,
  input wire SELECT_N_IN,
  input wire HOST_SERIAL_IN,
  output reg HOST_SERIAL_OUT,
  output reg HOST_SERIAL_OE_OUT,
  output reg SCAN_ENABLE_OUT,
  output reg SCAN_CLK_OUT,
  output reg SCAN_MODE_SEL_OUT,
  output reg SCAN_DATA_IN_OUT,
  input wire SCAN_DATA_OUT_IN,
  input wire [15:0] FAULT_FLAGS_IN,
  input wire [15:0] CHECK_FLAGS_IN,
  input wire [15:0] PIC_STD_IN,
  input wire [31:0] PAYLOAD_IN,
  input wire [63:0] RASTER_IN,
  output reg [15:0] FEATURE_OFF_OUT,
  output reg [15:0] FAULT_EN_OUT,
  output reg [79:0] ANC_IDS_OUT,
  output reg [223:0] REGION_OUT
);
  // ============================================================
  // input synchronisers: two flops each, second stage only is read
  reg [4:0] sync1_ff; // first stage
  reg [4:0] sync2_ff; // second stage
  reg clk_old_ff; // previous synced burst clock, for edge finding
  // reset puts every synced pin at its idle level: select high, and
  // burst clock, mode and data low, so no false edge follows reset
  // and the scan outputs stay quiet until the mode pin is really high
  always @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      sync1_ff <= 5'h08;
      sync2_ff <= 5'h08;
      clk_old_ff <= 1'b0;
    end else begin
      sync1_ff <= {MODE_TEST_IN, SELECT_N_IN, BURST_CLK_IN,
                   HOST_SERIAL_IN, SCAN_DATA_OUT_IN};
      sync2_ff <= sync1_ff;
      clk_old_ff <= sync2_ff[2];
    end
  end
  wire test_mode = sync2_ff[4]; // mode select level
  wire sel_n = sync2_ff[3]; // synced select
  wire bclk = sync2_ff[2]; // synced burst clock
  wire sdi = sync2_ff[1]; // synced serial input
  wire tdo_s = sync2_ff[0]; // synced scan return data
  wire port_on = ~test_mode & ~sel_n;
  // edges of the burst clock found in the system clock domain; a
  // burst half period must span at least one system cycle
  // the old value resets low, the idle level of the burst clock
  wire rise = bclk & ~clk_old_ff;
  wire fall = ~bclk & clk_old_ff;
  // ============================================================
  // shift state
  reg [4:0] cnt_ff; // bits taken in current word
  reg phase_ff; // 0 command, 1 data
  reg rd_ff; // latched read flag
  reg [5:0] addr_ff; // latched address
  reg [15:0] sh_ff; // input shifter
  reg [15:0] out_ff; // read data shifter
  reg done_ff; // data word finished, further bits ignored
  // read mux over all mapped addresses
  // it is used on the last command bit, so the address is formed from
  // the shifter and the live input bit; packed ranges are indexed by
  // their offset from the first address of the range
  reg [15:0] rdata;
  reg mapped; // address hit
  wire [5:0] cmd_addr = {sh_ff[4:0], sdi};
  always @* begin
    rdata = 16'h0000;
    mapped = 1'b1;
    if (cmd_addr == `SHRP_ADDR_FEATURE_OFF) begin
      rdata = FEATURE_OFF_OUT;
    end else if (cmd_addr == `SHRP_ADDR_FAULT_FLAGS) begin
      rdata = FAULT_FLAGS_IN; // packed flags share one address
    end else if (cmd_addr == `SHRP_ADDR_CHECK_FLAGS) begin
      rdata = CHECK_FLAGS_IN;
    end else if (cmd_addr == `SHRP_ADDR_PIC_STD) begin
      rdata = PIC_STD_IN;
    end else if (cmd_addr >= `SHRP_ADDR_ANC_FIRST &&
                 cmd_addr <= `SHRP_ADDR_ANC_LAST) begin
      rdata = ANC_IDS_OUT[(cmd_addr - `SHRP_ADDR_ANC_FIRST)*16 +: 16];
    end else if (cmd_addr >= `SHRP_ADDR_PAYLOAD_FIRST &&
                 cmd_addr <= `SHRP_ADDR_PAYLOAD_LAST) begin
      rdata = PAYLOAD_IN[(cmd_addr - `SHRP_ADDR_PAYLOAD_FIRST)*16 +: 16];
    end else if (cmd_addr >= `SHRP_ADDR_RASTER_FIRST &&
                 cmd_addr <= `SHRP_ADDR_RASTER_LAST) begin
      rdata = RASTER_IN[(cmd_addr - `SHRP_ADDR_RASTER_FIRST)*16 +: 16];
    end else if (cmd_addr >= `SHRP_ADDR_REGION_FIRST &&
                 cmd_addr <= `SHRP_ADDR_REGION_LAST) begin
      rdata = REGION_OUT[(cmd_addr - `SHRP_ADDR_REGION_FIRST)*16 +: 16];
    end else if (cmd_addr == `SHRP_ADDR_FAULT_EN) begin
      rdata = FAULT_EN_OUT;
    end else begin
      mapped = 1'b0;
      rdata = 16'h0000;
    end
  end
  // ============================================================
  // command and data shifting; deselect aborts and rearms
  wire [15:0] wword = {sh_ff[14:0], sdi}; // completed write word
  // the read word is snapshotted when the command ends, so a status
  // input that moves during the data word cannot tear the word
  // the first falling edge after the command is skipped: it only ends
  // the command's last bit, and the msb must stand until the host's
  // next rising edge
  // cnt_ff counts rising edges and wraps after each sixteen-bit word
  always @(posedge CLK_SYS_IN) begin
    // deselect or scan mode clears the engine, so every access starts
    // from bit zero whatever the previous host left behind
    if (RESET_IN || !port_on) begin
      cnt_ff <= 5'h00;
      phase_ff <= 1'b0;
      rd_ff <= 1'b0;
      addr_ff <= 6'h00;
      sh_ff <= 16'h0000;
      out_ff <= 16'h0000;
      done_ff <= 1'b0;
    end else if (rise && !done_ff) begin
      sh_ff <= wword; // msb first
      if (cnt_ff == `SHRP_WORD_BITS - 5'h01) begin
        cnt_ff <= 5'h00;
        if (!phase_ff) begin
          // end of command word
          phase_ff <= 1'b1;
          rd_ff <= sh_ff[14] == `SHRP_RW_READ;
          addr_ff <= cmd_addr;
          out_ff <= mapped ? rdata : 16'h0000;
        end else begin
          done_ff <= 1'b1; // one data word only
        end
      end else begin
        cnt_ff <= cnt_ff + 5'h01;
      end
    end else if (fall && phase_ff && rd_ff && cnt_ff != 5'h00) begin
      out_ff <= {out_ff[14:0], 1'b0};
    end
  end
  // ============================================================
  // writable register storage, updated when a write data word ends
  // writes land only on the sixteenth data bit, so a host that drops
  // select early leaves every register untouched
  // reads never reach the storage, only the snapshot shifter
  wire wr_done = port_on && rise && !done_ff && phase_ff && !rd_ff &&
                 cnt_ff == `SHRP_WORD_BITS - 5'h01;
  genvar gi;
  generate
    // one storage word per ancillary match id
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_anc
      localparam [31:0] anc_at = `SHRP_ADDR_ANC_FIRST + gi; // word address
      always @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
          ANC_IDS_OUT[gi*16 +: 16] <= `SHRP_RESET_WORD;
        end else if (wr_done && addr_ff == anc_at[5:0]) begin
          ANC_IDS_OUT[gi*16 +: 16] <= wword;
        end
      end
    end
    // one storage word per checkword region limit
    for (gi = 0; gi < 14; gi = gi + 1) begin : g_region
      localparam [31:0] region_at = `SHRP_ADDR_REGION_FIRST + gi; // address
      always @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
          REGION_OUT[gi*16 +: 16] <= `SHRP_RESET_WORD;
        end else if (wr_done && addr_ff == region_at[5:0]) begin
          REGION_OUT[gi*16 +: 16] <= wword;
        end
      end
    end
  endgenerate
  // single registers; unmapped and read-only addresses ignore writes
  // read-only and unmapped addresses have no storage here, so a
  // write to them falls through without any effect
  always @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      FEATURE_OFF_OUT <= `SHRP_RESET_WORD;
      FAULT_EN_OUT <= `SHRP_RESET_WORD;
    end else if (wr_done) begin
      if (addr_ff == `SHRP_ADDR_FEATURE_OFF) begin
        FEATURE_OFF_OUT <= wword;
      end
      if (addr_ff == `SHRP_ADDR_FAULT_EN) begin
        FAULT_EN_OUT <= wword;
      end
    end
  end
  // ============================================================
  // pin outputs: outside scan mode, serial out driven only while selected in read data
  // in scan mode the shared pins are only routed; the scan engine
  // itself sits outside this block, and its data leaves on the
  // serial out pin, which is then driven all the time
  // the enable drops once select rises, so a second device on the
  // shared line can answer right after
  always @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      HOST_SERIAL_OUT <= 1'b0;
      HOST_SERIAL_OE_OUT <= 1'b0;
      SCAN_ENABLE_OUT <= 1'b0;
      SCAN_CLK_OUT <= 1'b0;
      SCAN_MODE_SEL_OUT <= 1'b0;
      SCAN_DATA_IN_OUT <= 1'b0;
    end else begin
      SCAN_ENABLE_OUT <= test_mode;
      SCAN_CLK_OUT <= test_mode & bclk; // shared pin becomes scan clock
      SCAN_MODE_SEL_OUT <= test_mode & sel_n; // select pin as mode sel
      SCAN_DATA_IN_OUT <= test_mode & sdi;
      if (test_mode) begin
        HOST_SERIAL_OUT <= tdo_s; // scan data returns on serial out pin
        HOST_SERIAL_OE_OUT <= 1'b1;
      end else begin
        HOST_SERIAL_OUT <= out_ff[15];
        HOST_SERIAL_OE_OUT <= port_on & phase_ff & rd_ff & ~done_ff;
      end
    end
  end
endmodule

/* File: common/shrp_regs.vh */
// register map, command layout and timing constants of the serial host port
// Functional notes
// - host port active only while mode select low
// - mode select high: pins become boundary-scan port
// - test mode enables scan instead of register access
// - serial out high impedance unless selected; the code drives it all the time in scan mode
// - one 16-bit data word follows command
// - command msb first: rw, 9 reserved, address
// - serial input sampled on rising clock edge
// - read msb driven after command's last falling edge
// - remaining read bits shift on falling edges
// - every register individually addressable
// - narrow status registers may share one address
`ifndef SHRP_REGS_VH
`define SHRP_REGS_VH
// ============================================================
// register indices
`define SHRP_ADDR_FEATURE_OFF 6'h00
`define SHRP_ADDR_FAULT_FLAGS 6'h01
`define SHRP_ADDR_CHECK_FLAGS 6'h03
`define SHRP_ADDR_PIC_STD 6'h04
`define SHRP_ADDR_ANC_FIRST 6'h05
`define SHRP_ADDR_ANC_LAST 6'h09
`define SHRP_ADDR_PAYLOAD_FIRST 6'h12
`define SHRP_ADDR_PAYLOAD_LAST 6'h13
`define SHRP_ADDR_RASTER_FIRST 6'h14
`define SHRP_ADDR_RASTER_LAST 6'h17
`define SHRP_ADDR_REGION_FIRST 6'h18
`define SHRP_ADDR_REGION_LAST 6'h25
`define SHRP_ADDR_FAULT_EN 6'h26
// ============================================================
// command word layout
`define SHRP_CMD_RW_BIT 15
`define SHRP_CMD_ADDR_MSB 5
`define SHRP_RW_READ 1'b1
`define SHRP_WORD_BITS 5'h10
// ============================================================
// reset values of writable storage
`define SHRP_RESET_WORD 16'h0000
// ============================================================
// burst clock limit, kHz, and least system cycles per burst half period
`define SHRP_BURST_MAX_KHZ 6600
`define SHRP_SYS_KHZ 25000
`define SHRP_MIN_HALF_CYC ((`SHRP_SYS_KHZ / `SHRP_BURST_MAX_KHZ) / 2)
`endif

/* File: testbench/shrp_port_assertions.sv */
// checker for the serial host port pins
`timescale 1ns/1ns
module shrp_port_assertions (
  input wire CLK_SYS_IN,
  input wire RESET_IN,
  input wire MODE_TEST_IN,
  input wire BURST_CLK_IN,
  input wire SELECT_N_IN,
  input wire HOST_SERIAL_IN,
  input wire HOST_SERIAL_OUT,
  input wire HOST_SERIAL_OE_OUT,
  input wire SCAN_ENABLE_OUT,
  input wire SCAN_CLK_OUT,
  input wire SCAN_MODE_SEL_OUT,
  input wire SCAN_DATA_IN_OUT,
  input wire [15:0] FEATURE_OFF_OUT
);
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RESET_IN);
  // the synchronisers need a few cycles, hence the long antecedents
  scan_enable_a: assert property (MODE_TEST_IN[*5]
    |-> SCAN_ENABLE_OUT && HOST_SERIAL_OE_OUT)
    else $error("scan mode not taken");
  scan_quiet_a: assert property ((!MODE_TEST_IN)[*5]
    |-> !SCAN_ENABLE_OUT && !SCAN_CLK_OUT && !SCAN_MODE_SEL_OUT &&
    !SCAN_DATA_IN_OUT) else $error("scan pins busy");
  scan_select_a: assert property (
    (MODE_TEST_IN && $stable(SELECT_N_IN))[*6]
    |-> SCAN_MODE_SEL_OUT == SELECT_N_IN)
    else $error("scan select not routed");
  // the burst clock moves every four cycles in scan mode, so three stable
  // samples once the mode is taken are the longest window it leaves
  scan_clock_a: assert property (
    (MODE_TEST_IN && SCAN_ENABLE_OUT && $stable(BURST_CLK_IN))[*3]
    |-> SCAN_CLK_OUT == BURST_CLK_IN)
    else $error("scan clock not routed");
  scan_data_a: assert property (
    (MODE_TEST_IN && SCAN_ENABLE_OUT && $stable(HOST_SERIAL_IN))[*3]
    |-> SCAN_DATA_IN_OUT == HOST_SERIAL_IN)
    else $error("scan data not routed");
  oe_idle_a: assert property (
    (SELECT_N_IN && !MODE_TEST_IN)[*6] |-> !HOST_SERIAL_OE_OUT)
    else $error("driven while idle");
  oe_release_a: assert property (
    $rose(SELECT_N_IN) && !MODE_TEST_IN |-> ##[1:6] !HOST_SERIAL_OE_OUT)
    else $error("no release");
  oe_start_a: assert property (
    $rose(HOST_SERIAL_OE_OUT) && !MODE_TEST_IN && !SCAN_ENABLE_OUT
    |-> $past(BURST_CLK_IN, 3) && !$past(BURST_CLK_IN, 6))
    else $error("read start off");
  read_hold_a: assert property (
    $rose(BURST_CLK_IN) && HOST_SERIAL_OE_OUT && !SCAN_ENABLE_OUT
    |-> ##2 ($stable(HOST_SERIAL_OUT) || !HOST_SERIAL_OE_OUT)[*5])
    else $error("read bit moved");
  rw_mode_a: assert property (
    $changed(FEATURE_OFF_OUT) |-> !SCAN_ENABLE_OUT)
    else $error("write in scan mode");
endmodule

/* File: testbench/shrp_host_model.sv */
// host model: drives burst clock, select and serial input
`timescale 1ns/1ns
module shrp_host_model (
  input wire clk_in,
  input wire sdo_in,
  output reg sck_out,
  output reg cs_n_out,
  output reg sdi_out
);
  // burst clock stands low between accesses
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  // half of a 320 ns burst period
  task half;
    repeat (4) @(negedge clk_in);
  endtask
  // n bits of command then data, msb first; n below 32 aborts
  // read bits are taken at the rising edge, as a real host does
  task xfer(input [15:0] cmd, input [15:0] wd, input integer n,
            output [15:0] rd);
    integer i;
    begin
      cs_n_out = 1'b0;
      for (i = 31; i > 31 - n; i = i - 1) begin
        sdi_out = (i > 15) ? cmd[i - 16] : wd[i];
        half;
        // the msb of a read stands from the command's last fall on
        if (i < 16) rd[i] = sdo_in;
        sck_out = 1'b1;
        half;
        sck_out = 1'b0;
      end
      half;
      cs_n_out = 1'b1;
      sdi_out = ~sdi_out;
      half;
    end
  endtask
endmodule

/* File: testbench/tb.sv */
// top testbench of the serial host register port
`timescale 1ns/1ns
module tb;
  reg clk = 0;
  reg rst = 1;
  reg mode = 0;
  reg scan_ret = 0;
  integer failures = 0;
  integer checks = 0;
  integer cyc = 0;
  integer a, j, k;
  reg [15:0] e [0:63]; // model of every address, zero where unmapped
  reg [15:0] rd;
  wire sck, cs_n, sdi, so, oe, sen, s_ck, s_ms, s_di;
  wire sdo = oe ? so : 1'bz; // pin resolved from the enable
  wire [15:0] feat, fen;
  wire [79:0] anc;
  wire [223:0] reg_o;
  initial forever #20 clk = ~clk;
  shrp_host_model HOST (.clk_in(clk), .sdo_in(sdo), .sck_out(sck),
    .cs_n_out(cs_n), .sdi_out(sdi));
  shrp_port DUT (.CLK_SYS_IN(clk), .RESET_IN(rst), .MODE_TEST_IN(mode),
    .BURST_CLK_IN(sck), .SELECT_N_IN(cs_n), .HOST_SERIAL_IN(sdi),
    .HOST_SERIAL_OUT(so), .HOST_SERIAL_OE_OUT(oe), .SCAN_ENABLE_OUT(sen),
    .SCAN_CLK_OUT(s_ck), .SCAN_MODE_SEL_OUT(s_ms), .SCAN_DATA_IN_OUT(s_di),
    .SCAN_DATA_OUT_IN(scan_ret), .FAULT_FLAGS_IN(e[1]),
    .CHECK_FLAGS_IN(e[3]), .PIC_STD_IN(e[4]), .PAYLOAD_IN({e[19], e[18]}),
    .RASTER_IN({e[23], e[22], e[21], e[20]}), .FEATURE_OFF_OUT(feat),
    .FAULT_EN_OUT(fen), .ANC_IDS_OUT(anc), .REGION_OUT(reg_o));
  // ============================================================
  // checking and closing
  task chk(input [15:0] s, input [15:0] x);
    begin
      checks = checks + 1;
      if (s !== x) begin
        failures = failures + 1;
        $display("BAD %0t seen %h want %h", $time, s, x);
      end
    end
  endtask
  task give_verdict;
    begin
      if (failures == 0 && checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // writable places: feature word, ancillary ids, regions, fault enables
  function wr(input integer a);
    wr = a == 0 || (a >= 5 && a <= 9) || (a >= 24 && a <= 38);
  endfunction
  // one access with random reserved bits and data
  task acc(input rw, input integer a, input integer n);
    reg [15:0] wd;
    begin
      wd = 16'($urandom);
      HOST.xfer({rw, 9'($urandom), 6'(a)}, wd, n, rd);
      if (rw) chk(rd, e[a]);
      else if (wr(a) && n == 32 && !mode) e[a] = wd;
    end
  endtask
  // writable outputs against the model
  task outs;
    begin
      chk(feat, e[0]);
      chk(fen, e[38]);
      for (k = 0; k < 5; k = k + 1)
        chk(anc[16*k+:16], e[5+k]);
      for (k = 0; k < 14; k = k + 1)
        chk(reg_o[16*k+:16], e[24+k]);
    end
  endtask
  // a hang counts as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      failures = failures + 1;
      give_verdict;
    end
  end
  initial begin
    a = $urandom(18);
    for (a = 0; a < 64; a = a + 1)
      e[a] = (a == 1 || a == 3 || a == 4 || (a >= 18 && a <= 23)) ?
             16'($urandom) : 16'h0000;
    repeat (12) @(negedge clk);
    rst = 0;
    repeat (4) @(negedge clk);
    outs; // reset values
    // read all, write all back to back, read all again
    for (j = 0; j < 3; j = j + 1)
      for (a = 0; a < 64; a = a + 1)
        acc(j != 1, a, 32);
    outs;
    acc(0, 0, 24); // deselect mid-data must not write
    acc(1, 0, 32);
    // scan mode: pins rerouted, register writes blocked
    mode = 1;
    scan_ret = 1'($urandom);
    repeat (6) @(negedge clk);
    chk(sdo, scan_ret);
    chk(s_ms, 1'b1);
    chk(s_ck, sck);
    chk(s_di, sdi);
    acc(0, 38, 32);
    mode = 0;
    repeat (6) @(negedge clk);
    acc(1, 38, 32);
    outs;
    give_verdict;
  end
endmodule
bind shrp_port shrp_port_assertions CHK (.CLK_SYS_IN, .RESET_IN,
  .MODE_TEST_IN, .BURST_CLK_IN, .SELECT_N_IN, .HOST_SERIAL_IN,
  .HOST_SERIAL_OUT,
  .HOST_SERIAL_OE_OUT, .SCAN_ENABLE_OUT, .SCAN_CLK_OUT, .SCAN_MODE_SEL_OUT,
  .SCAN_DATA_IN_OUT, .FEATURE_OFF_OUT);
